// ### pkg/oscsw_pkg.sv
// oscillator switch control: register map, field positions, reset values, codes
// assumes a 32-bit apb slave with each register on one aligned word
`default_nettype none
package oscsw_pkg;
    // register byte addresses
    localparam logic [3:0] ADDR_OSC_CTRL = 4'h0;
    localparam logic [3:0] ADDR_CLK_DIV = 4'h4;
    localparam logic [3:0] ADDR_FRC_TRIM = 4'h8;
    localparam logic [3:0] ADDR_OSC_STAT = 4'hc;
    // oscillator_control fields
    localparam int CUR_LSB = 12;
    localparam int NEXT_LSB = 8;
    localparam int FREEZE_BIT = 7;
    localparam int LOCK_BIT = 5;
    localparam int FAIL_BIT = 3;
    localparam int DRIVE_BIT = 2;
    localparam int SEC_EN_BIT = 1;
    localparam int SWREQ_BIT = 0;
    // clock_divider fields
    localparam int WAKE_BIT = 15;
    localparam int RATIO_LSB = 12;
    localparam int SLOW_EN_BIT = 11;
    localparam int POST_LSB = 8;
    // unlock keys, high byte then low byte
    localparam logic [7:0] KEY_HI_1 = 8'h78;
    localparam logic [7:0] KEY_HI_2 = 8'h9a;
    localparam logic [7:0] KEY_LO_1 = 8'h46;
    localparam logic [7:0] KEY_LO_2 = 8'h57;
    // reset values
    localparam logic [2:0] RATIO_RESET = 3'h3;
    localparam logic [2:0] POST_RESET = 3'h1;
    localparam logic [5:0] TRIM_RESET = 6'h00;
    // cycles of the new clock counted before change-over
    localparam logic [3:0] SETTLE_CYCLES = 4'ha;
    // source encodings
    localparam logic [2:0] SRC_FRC = 3'h0;
    localparam logic [2:0] SRC_FRC_PLL = 3'h1;
    localparam logic [2:0] SRC_PRI = 3'h2;
    localparam logic [2:0] SRC_PRI_PLL = 3'h3;
    localparam logic [2:0] SRC_SEC = 3'h4;
    localparam logic [2:0] SRC_LOW_POWER_RC_OSCILLATOR = 3'h5;
    localparam logic [2:0] SRC_LPFRC_DIV = 3'h6;
    localparam logic [2:0] SRC_FRC_DIV = 3'h7;
    // switch sequencer states, gray from idle up to change; change back to idle flips two bits
    typedef enum logic [2:0] {
        SW_IDLE = 3'b000,
        SW_START = 3'b001,
        SW_WAIT_READY = 3'b011,
        SW_SETTLE = 3'b010,
        SW_CHANGE = 3'b110
    } oscsw_state_t;
    // unlock tracker
    typedef enum logic [1:0] {
        UL_LOCKED = 2'b00,
        UL_FIRST = 2'b01,
        UL_OPEN = 2'b11
    } oscsw_unlock_t;
endpackage
`default_nettype wire

// ### verification/oscsw_chk_sva.sv
// checker for the oscillator switch control: apb reads and source outputs
// assumes keep-alive and secondary enable stay steady while a switch runs
`default_nettype none
module oscsw_chk (
    // bus
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [3:0] paddr,
    input wire logic [31:0] prdata,
    // configuration and sources
    input wire logic switch_config_bit,
    input wire logic source_ready,
    input wire logic new_clock_tick,
    input wire logic clock_failure,
    input wire logic low_power_rc_oscillator_keep_alive,
    input wire logic [7:0] source_power,
    input wire logic [2:0] clock_select,
    // consumers
    input wire logic [7:0] slowdown_ratio,
    input wire logic [8:0] postscale_divide,
    input wire logic [5:0] fast_rc_trim
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic rd_ctrl;
    logic rd_div;
    logic [3:0] ticks;
    assign rd_ctrl = psel && !pwrite && paddr == oscsw_pkg::ADDR_OSC_CTRL;
    assign rd_div = psel && penable && !pwrite && paddr == oscsw_pkg::ADDR_CLK_DIV;
    // restarts when power changes, so idle ticks of the old source never count
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) ticks <= 4'h0;
        else if ($changed(source_power)) ticks <= 4'h0;
        else if (new_clock_tick && source_ready && ticks != 4'hf) ticks <= ticks + 4'h1;
    end
    property p_settle;
        $changed(clock_select) |-> $past(ticks) >= 4'ha;
    endproperty
    a_settle: assert property (p_settle) else $error("early change");
    property p_ready;
        $changed(clock_select) |-> $past(source_ready);
    endproperty
    a_ready: assert property (p_ready) else $error("change without ready");
    property p_power;
        $changed(clock_select) && !low_power_rc_oscillator_keep_alive
            |=> (source_power & 8'hcf) == ((8'h01 << clock_select) & 8'hcf);
    endproperty
    a_power: assert property (p_power) else $error("old source on");
    property p_cur;
        rd_ctrl && clk_en |=> clock_select == $past(prdata[14:12]);
    endproperty
    a_cur: assert property (p_cur) else $error("current field");
    property p_nolock;
        rd_ctrl && prdata[14:12] != 3'h1 && prdata[14:12] != 3'h3 |-> !prdata[5];
    endproperty
    a_nolock: assert property (p_nolock) else $error("lock in non-pll");
    property p_swoff;
        switch_config_bit && $past(switch_config_bit) && rd_ctrl |-> !prdata[0];
    endproperty
    a_swoff: assert property (p_swoff) else $error("request while off");
    property p_fail;
        clock_failure && clk_en ##1 rd_ctrl |-> prdata[3];
    endproperty
    a_fail: assert property (p_fail) else $error("fail flag");
    property p_trim;
        psel && !pwrite && paddr == oscsw_pkg::ADDR_FRC_TRIM |-> prdata == {26'h0, fast_rc_trim};
    endproperty
    a_trim: assert property (p_trim) else $error("trim");
    property p_ratio;
        rd_div && $stable(prdata)
            |-> slowdown_ratio == (prdata[11] ? 8'h01 << prdata[14:12] : 8'h01);
    endproperty
    a_ratio: assert property (p_ratio) else $error("ratio");
    property p_post;
        rd_div && $stable(prdata) && clock_select == 3'h7
            |-> postscale_divide == (prdata[10:8] == 3'h7 ? 9'h100 : 9'h001 << prdata[10:8]);
    endproperty
    a_post: assert property (p_post) else $error("postscale");
endmodule
bind oscsw_ctrl oscsw_chk u_chk (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .switch_config_bit(switch_config_bit),
    .source_ready(source_ready), .new_clock_tick(new_clock_tick),
    .clock_failure(clock_failure), .low_power_rc_oscillator_keep_alive(low_power_rc_oscillator_keep_alive),
    .source_power(source_power), .clock_select(clock_select),
    .slowdown_ratio(slowdown_ratio), .postscale_divide(postscale_divide),
    .fast_rc_trim(fast_rc_trim)
);
`default_nettype wire

// ### verification/oscsw_src_model.sv
// model of the oscillator sources and pll seen by the switch control
// assumes the bench names the source being started on target
`default_nettype none
module oscsw_src_model (
    // timing
    input wire logic pclk,
    input wire logic presetn,
    // bench control
    input wire logic [2:0] target,
    input wire logic slow,
    // from the control block
    input wire logic [7:0] source_power,
    input wire logic pll_enable,
    // to the control block
    output logic source_ready,
    output logic new_clock_tick,
    output logic pll_locked,
    output logic pll_timer_done
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] rc;
    logic [7:0] lc;
    logic [1:0] div;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rc <= 8'h0;
            lc <= 8'h0;
            div <= 2'h0;
        end else begin
            rc <= source_power[target] ? rc + {7'h0, rc != 8'hff} : 8'h0;
            lc <= pll_enable ? lc + {7'h0, lc != 8'hff} : 8'h0;
            div <= div + 2'h1;
        end
    end
    // a slow source starts late and its pll is trusted only through the timer
    assign source_ready = rc >= (slow ? 8'd60 : 8'd4);
    assign new_clock_tick = source_ready && div == 2'h0;
    assign pll_locked = !slow && lc >= 8'd20;
    assign pll_timer_done = slow && lc >= 8'd80;
endmodule
`default_nettype wire

// ### verification/tb.sv
// testbench for the oscillator switch control
// assumes a zero-wait apb slave and the source model beside it
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic [3:0] a; logic [31:0] d; logic [31:0] e;} oscsw_row_t;
    logic pclk = 1'b0, presetn = 1'b0, clk_en = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [3:0] paddr = 4'h0, pstrb = 4'h0;
    logic [31:0] pwdata = 32'h0, prdata, rv;
    logic pready, pslverr, pll_enable, secondary_high_power, slow = 1'b0;
    logic switch_config_bit = 1'b0, monitor_config_bit = 1'b0, secondary_source_config = 1'b0;
    logic source_ready, new_clock_tick, pll_locked, pll_timer_done;
    logic clock_failure = 1'b0, low_power_rc_oscillator_keep_alive = 1'b0, interrupt_event = 1'b0;
    logic [7:0] source_power, slowdown_ratio;
    logic [2:0] clock_select, target = 3'h0;
    logic [8:0] postscale_divide;
    logic [5:0] fast_rc_trim;
    int err_count = 0, samples_checked = 0, cycles = 0;
    oscsw_row_t rows [7] = '{'{4'h8, 32'hffffffff, 32'h3f}, '{4'h8, 32'h20, 32'h20},
        '{4'h8, 32'h1f, 32'h1f}, '{4'h4, 32'hffff, 32'hff00}, '{4'h4, 32'h3800, 32'h3800},
        '{4'h4, 32'h0600, 32'h0600}, '{4'h0, 32'hff07, 32'h7700}};
    oscsw_ctrl dut (
        .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .switch_config_bit(switch_config_bit),
        .monitor_config_bit(monitor_config_bit), .secondary_source_config(secondary_source_config),
        .source_ready(source_ready), .new_clock_tick(new_clock_tick), .pll_locked(pll_locked),
        .pll_timer_done(pll_timer_done), .clock_failure(clock_failure),
        .low_power_rc_oscillator_keep_alive(low_power_rc_oscillator_keep_alive), .source_power(source_power),
        .clock_select(clock_select), .pll_enable(pll_enable),
        .secondary_high_power(secondary_high_power), .interrupt_event(interrupt_event),
        .slowdown_ratio(slowdown_ratio), .postscale_divide(postscale_divide),
        .fast_rc_trim(fast_rc_trim)
    );
    oscsw_src_model model (
        .pclk(pclk), .presetn(presetn), .target(target), .slow(slow),
        .source_power(source_power), .pll_enable(pll_enable), .source_ready(source_ready),
        .new_clock_tick(new_clock_tick), .pll_locked(pll_locked), .pll_timer_done(pll_timer_done)
    );
    initial begin
        forever #20 pclk = ~pclk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic end_sim();
        $display("checked %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic apb(input logic [3:0] a, input logic w, input logic [31:0] d,
                       input logic [3:0] s);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rv = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
        apb(a, 1'b1, d, s);
    endtask
    task automatic rd(input logic [3:0] a);
        apb(a, 1'b0, 32'h0, 4'h0);
    endtask
    task automatic lo(input logic [7:0] v);
        wr(4'h0, {24'h0, oscsw_pkg::KEY_LO_1}, 4'h1);
        wr(4'h0, {24'h0, oscsw_pkg::KEY_LO_2}, 4'h1);
        wr(4'h0, {24'h0, v}, 4'h1);
    endtask
    task automatic sw(input logic [2:0] n, input logic [7:0] v);
        wr(4'h0, {16'h0, oscsw_pkg::KEY_HI_1, 8'h0}, 4'h2);
        wr(4'h0, {16'h0, oscsw_pkg::KEY_HI_2, 8'h0}, 4'h2);
        wr(4'h0, {21'h0, n, 8'h0}, 4'h2);
        lo(v);
    endtask
    task automatic wait_sw();
        for (int i = 0; i < 100; i++) begin
            rd(4'h0);
            if (rv[0] === 1'b0) break;
        end
    endtask
    task automatic irq();
        interrupt_event <= 1'b1;
        @(posedge pclk);
        interrupt_event <= 1'b0;
        rd(4'h4);
    endtask
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            err_count++;
            end_sim();
        end
    end
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d, 4'hf);
            rd(rows[i].a);
            chk(rv, rows[i].e);
        end
        wr(4'h4, 32'hb800, 4'hf);
        rd(4'h4);
        chk({24'h0, slowdown_ratio}, 32'h8);
        irq();
        chk(rv, 32'hb000);
        chk({24'h0, slowdown_ratio}, 32'h1);
        wr(4'h4, 32'h3800, 4'hf);
        irq();
        chk(rv, 32'h3800);
        sw(oscsw_pkg::SRC_FRC, 8'h01);
        rd(4'h0);
        chk(rv, 32'h7001);
        wait_sw();
        chk(rv, 32'h0);
        lo(8'h01);
        rd(4'h0);
        chk(rv, 32'h0);
        clock_failure <= 1'b1;
        rd(4'h0);
        clock_failure <= 1'b0;
        chk(rv, 32'h8);
        target <= oscsw_pkg::SRC_PRI_PLL;
        slow <= 1'b1;
        sw(oscsw_pkg::SRC_PRI_PLL, 8'h09);
        rd(4'h0);
        chk(rv, 32'h0301);
        wait_sw();
        chk(rv, 32'h3320);
        slow <= 1'b0;
        clock_failure <= 1'b1;
        rd(4'h0);
        clock_failure <= 1'b0;
        lo(8'h00);
        rd(4'h0);
        chk(rv, 32'h3320);
        target <= oscsw_pkg::SRC_FRC;
        sw(oscsw_pkg::SRC_FRC, 8'h01);
        wait_sw();
        chk(rv, 32'h0);
        wr(4'h0, {24'h0, oscsw_pkg::KEY_LO_1}, 4'h1);
        wr(4'h0, 32'h0, 4'h1);
        wr(4'h0, {24'h0, oscsw_pkg::KEY_LO_2}, 4'h1);
        wr(4'h0, 32'h06, 4'h1);
        rd(4'h0);
        chk(rv, 32'h0);
        lo(8'h06);
        rd(4'h0);
        chk(rv, 32'h06);
        chk({30'h0, secondary_high_power, source_power[4]}, 32'h3);
        lo(8'h00);
        secondary_source_config <= 1'b1;
        rd(4'h0);
        chk({30'h0, secondary_high_power, source_power[4]}, 32'h2);
        switch_config_bit <= 1'b1;
        target <= oscsw_pkg::SRC_PRI;
        sw(oscsw_pkg::SRC_PRI, 8'h01);
        repeat (60) @(posedge pclk);
        rd(4'h0);
        chk(rv & 32'h7001, 32'h0);
        switch_config_bit <= 1'b0;
        lo(8'h80);
        sw(oscsw_pkg::SRC_PRI, 8'h81);
        repeat (80) @(posedge pclk);
        rd(4'h0);
        chk(rv & 32'h7081, 32'h80);
        monitor_config_bit <= 1'b1;
        sw(oscsw_pkg::SRC_PRI, 8'h81);
        wait_sw();
        chk(rv & 32'h7081, 32'h2080);
        low_power_rc_oscillator_keep_alive <= 1'b1;
        rd(4'h0);
        chk({24'h0, source_power}, 32'h24);
        low_power_rc_oscillator_keep_alive <= 1'b0;
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(4'h0);
        chk(rv, 32'h7700);
        rd(4'h4);
        chk(rv, 32'h3100);
        clk_en <= 1'b0;
        wr(4'h8, 32'h15, 4'hf);
        clk_en <= 1'b1;
        rd(4'h8);
        chk(rv, 32'h0);
        end_sim();
    end
endmodule
`default_nettype wire

// ### verilog/oscsw_ctrl.sv
// oscillator switch control: apb registers, byte unlock, hardware switch sequencer
// assumes source ready and new-clock edge inputs are synchronous to pclk
//
// The placing of the registers and the APB slave port are this design's own decisions.
`default_nettype none

module oscsw_ctrl #(
    parameter logic [2:0] INIT_SOURCE = 3'h7
) (
    // apb slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [3:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // configuration straps
    input wire logic switch_config_bit,
    input wire logic monitor_config_bit,
    input wire logic secondary_source_config,
    // oscillator sources and pll
    input wire logic source_ready,
    input wire logic new_clock_tick,
    input wire logic pll_locked,
    input wire logic pll_timer_done,
    input wire logic clock_failure,
    input wire logic low_power_rc_oscillator_keep_alive,
    output logic [7:0] source_power,
    output logic [2:0] clock_select,
    output logic pll_enable,
    output logic secondary_high_power,
    // clock consumers
    input wire logic interrupt_event,
    output logic [7:0] slowdown_ratio,
    output logic [8:0] postscale_divide,
    output logic [5:0] fast_rc_trim
);

    logic [2:0] cur_src_reg;
    logic [2:0] next_src_reg;
    logic freeze_reg;
    logic fail_reg;
    logic drive_reg;
    logic sec_en_reg;
    logic swreq_reg;
    logic wake_reg;
    logic [2:0] ratio_reg;
    logic slow_en_reg;
    logic [2:0] post_reg;
    logic [5:0] trim_reg;
    logic [7:0] power_reg;
    logic [3:0] settle_reg;
    logic init_done_reg;
    oscsw_pkg::oscsw_state_t state_reg;
    oscsw_pkg::oscsw_unlock_t ul_hi_reg;
    oscsw_pkg::oscsw_unlock_t ul_lo_reg;

    logic access;
    logic wr_ctrl_hi;
    logic wr_ctrl_lo;
    logic switch_on;
    logic pll_src;
    logic valid_start;
    logic [7:0] wb_hi;
    logic [7:0] wb_lo;

    function automatic logic uses_pll(input logic [2:0] src);
        uses_pll = (src == oscsw_pkg::SRC_PRI_PLL) || (src == oscsw_pkg::SRC_FRC_PLL);
    endfunction

    function automatic logic [7:0] onehot(input logic [2:0] src);
        onehot = 8'h01 << src;
    endfunction

    // apb: zero wait states, every address answers without error
    assign access = psel && penable && clk_en;
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign wb_hi = pwdata[15:8];
    assign wb_lo = pwdata[7:0];
    assign wr_ctrl_hi = access && pwrite && (paddr == oscsw_pkg::ADDR_OSC_CTRL) && pstrb[1];
    assign wr_ctrl_lo = access && pwrite && (paddr == oscsw_pkg::ADDR_OSC_CTRL) && pstrb[0];
    assign switch_on = !switch_config_bit;
    assign pll_src = uses_pll(cur_src_reg);
    assign valid_start = (state_reg == oscsw_pkg::SW_START) && (next_src_reg != cur_src_reg);

    // unlock trackers: a key write is never a data write, anything else relocks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ul_hi_reg <= oscsw_pkg::UL_LOCKED;
        end else if (wr_ctrl_hi) begin
            if (ul_hi_reg == oscsw_pkg::UL_LOCKED && wb_hi == oscsw_pkg::KEY_HI_1) begin
                ul_hi_reg <= oscsw_pkg::UL_FIRST;
            end else if (ul_hi_reg == oscsw_pkg::UL_FIRST && wb_hi == oscsw_pkg::KEY_HI_2) begin
                ul_hi_reg <= oscsw_pkg::UL_OPEN;
            end else begin
                ul_hi_reg <= oscsw_pkg::UL_LOCKED;
            end
        end else if (access) begin
            ul_hi_reg <= oscsw_pkg::UL_LOCKED;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ul_lo_reg <= oscsw_pkg::UL_LOCKED;
        end else if (wr_ctrl_lo) begin
            if (ul_lo_reg == oscsw_pkg::UL_LOCKED && wb_lo == oscsw_pkg::KEY_LO_1) begin
                ul_lo_reg <= oscsw_pkg::UL_FIRST;
            end else if (ul_lo_reg == oscsw_pkg::UL_FIRST && wb_lo == oscsw_pkg::KEY_LO_2) begin
                ul_lo_reg <= oscsw_pkg::UL_OPEN;
            end else begin
                ul_lo_reg <= oscsw_pkg::UL_LOCKED;
            end
        end else if (access) begin
            ul_lo_reg <= oscsw_pkg::UL_LOCKED;
        end
    end

    // next source: writable only through an open high byte, and not while frozen with monitor_config_bit low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            next_src_reg <= INIT_SOURCE;
        end else if (clk_en && wr_ctrl_hi && ul_hi_reg == oscsw_pkg::UL_OPEN
                     && !(freeze_reg && !monitor_config_bit)) begin
            next_src_reg <= wb_hi[2:0];
        end
    end

    // current source follows the initial selection until a change-over
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur_src_reg <= INIT_SOURCE;
        end else if (clk_en && state_reg == oscsw_pkg::SW_CHANGE) begin
            cur_src_reg <= next_src_reg;
        end
    end

    // low byte control bits; freeze is set-only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            freeze_reg <= 1'b0;
            drive_reg <= 1'b0;
            sec_en_reg <= 1'b0;
        end else if (clk_en && wr_ctrl_lo && ul_lo_reg == oscsw_pkg::UL_OPEN) begin
            freeze_reg <= freeze_reg | wb_lo[oscsw_pkg::FREEZE_BIT];
            drive_reg <= wb_lo[oscsw_pkg::DRIVE_BIT];
            sec_en_reg <= wb_lo[oscsw_pkg::SEC_EN_BIT];
        end
    end

    // switch request: set by unlocked write, cleared by sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            swreq_reg <= 1'b0;
        end else if (clk_en) begin
            if (!switch_on) begin
                swreq_reg <= 1'b0;
            end else if (wr_ctrl_lo && ul_lo_reg == oscsw_pkg::UL_OPEN
                         && wb_lo[oscsw_pkg::SWREQ_BIT] && !swreq_reg
                         && !(freeze_reg && !monitor_config_bit)) begin
                swreq_reg <= 1'b1;
            end else if (state_reg == oscsw_pkg::SW_START && next_src_reg == cur_src_reg) begin
                swreq_reg <= 1'b0;
            end else if (state_reg == oscsw_pkg::SW_CHANGE) begin
                swreq_reg <= 1'b0;
            end
        end
    end

    // fail flag: detection wins over a software clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fail_reg <= 1'b0;
        end else if (clk_en) begin
            if (clock_failure) begin
                fail_reg <= 1'b1;
            end else if (valid_start) begin
                fail_reg <= 1'b0;
            end else if (wr_ctrl_lo && ul_lo_reg == oscsw_pkg::UL_OPEN
                         && !wb_lo[oscsw_pkg::FAIL_BIT]) begin
                fail_reg <= 1'b0;
            end
        end
    end

    // switch sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= oscsw_pkg::SW_IDLE;
            settle_reg <= 4'h0;
        end else if (clk_en) begin
            case (state_reg)
                oscsw_pkg::SW_IDLE: begin
                    if (swreq_reg) begin
                        state_reg <= oscsw_pkg::SW_START;
                    end
                end
                oscsw_pkg::SW_START: begin
                    if (next_src_reg == cur_src_reg) begin
                        state_reg <= oscsw_pkg::SW_IDLE;
                    end else begin
                        state_reg <= oscsw_pkg::SW_WAIT_READY;
                    end
                end
                oscsw_pkg::SW_WAIT_READY: begin
                    // pll sources wait for lock status: locked or start-up timer satisfied
                    if (source_ready && (!uses_pll(next_src_reg)
                                         || pll_locked || pll_timer_done)) begin
                        state_reg <= oscsw_pkg::SW_SETTLE;
                        settle_reg <= 4'h0;
                    end
                end
                oscsw_pkg::SW_SETTLE: begin
                    if (new_clock_tick) begin
                        if (settle_reg == oscsw_pkg::SETTLE_CYCLES - 4'h1) begin
                            state_reg <= oscsw_pkg::SW_CHANGE;
                        end
                        settle_reg <= settle_reg + 4'h1;
                    end
                end
                oscsw_pkg::SW_CHANGE: begin
                    state_reg <= oscsw_pkg::SW_IDLE;
                end
                default: begin
                    state_reg <= oscsw_pkg::SW_IDLE;
                end
            endcase
        end
    end

    // source power: new one on from start, old one off after change-over
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            power_reg <= 8'h00;
            init_done_reg <= 1'b0;
        end else if (clk_en) begin
            if (!init_done_reg) begin
                power_reg <= onehot(cur_src_reg);
                init_done_reg <= 1'b1;
            end else if (state_reg == oscsw_pkg::SW_START && next_src_reg != cur_src_reg) begin
                power_reg <= power_reg | onehot(next_src_reg);
            end else if (state_reg == oscsw_pkg::SW_CHANGE) begin
                power_reg <= onehot(next_src_reg);
            end
        end
    end

    always_comb begin
        source_power = power_reg;
        source_power[oscsw_pkg::SRC_SEC] = power_reg[oscsw_pkg::SRC_SEC] | sec_en_reg;
        if (low_power_rc_oscillator_keep_alive) begin
            source_power[oscsw_pkg::SRC_LOW_POWER_RC_OSCILLATOR] = 1'b1;
        end
    end

    // clock divider and trim registers; interrupt wins over a write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_reg <= 1'b0;
            ratio_reg <= oscsw_pkg::RATIO_RESET;
            slow_en_reg <= 1'b0;
            post_reg <= oscsw_pkg::POST_RESET;
        end else if (clk_en) begin
            if (access && pwrite && paddr == oscsw_pkg::ADDR_CLK_DIV && pstrb[1]) begin
                wake_reg <= pwdata[oscsw_pkg::WAKE_BIT];
                ratio_reg <= pwdata[oscsw_pkg::RATIO_LSB +: 3];
                slow_en_reg <= pwdata[oscsw_pkg::SLOW_EN_BIT];
                post_reg <= pwdata[oscsw_pkg::POST_LSB +: 3];
            end
            if (interrupt_event && wake_reg) begin
                slow_en_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trim_reg <= oscsw_pkg::TRIM_RESET;
        end else if (clk_en && access && pwrite && paddr == oscsw_pkg::ADDR_FRC_TRIM
                     && pstrb[0]) begin
            trim_reg <= pwdata[5:0];
        end
    end

    // outputs to sources and consumers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clock_select <= INIT_SOURCE;
            pll_enable <= 1'b0;
            secondary_high_power <= 1'b0;
            slowdown_ratio <= 8'h00;
            postscale_divide <= 9'h001;
            fast_rc_trim <= 6'h00;
        end else if (clk_en) begin
            clock_select <= cur_src_reg;
            pll_enable <= pll_src || (state_reg != oscsw_pkg::SW_IDLE && uses_pll(next_src_reg));
            secondary_high_power <= drive_reg || secondary_source_config;
            slowdown_ratio <= slow_en_reg ? onehot(ratio_reg) : 8'h01;
            if (cur_src_reg == oscsw_pkg::SRC_FRC_DIV || cur_src_reg == oscsw_pkg::SRC_LPFRC_DIV) begin
                postscale_divide <= (post_reg == 3'h7) ? 9'h100 : {1'b0, onehot(post_reg)};
            end else begin
                postscale_divide <= 9'h001;
            end
            fast_rc_trim <= trim_reg;
        end
    end

    // read mux
    logic lock_view;
    always_comb begin
        // lock hidden during a switch and in non-pll modes
        lock_view = (pll_locked || pll_timer_done) && pll_src
                    && state_reg == oscsw_pkg::SW_IDLE;
        prdata = 32'h0;
        case (paddr)
            oscsw_pkg::ADDR_OSC_CTRL: begin
                prdata[oscsw_pkg::CUR_LSB +: 3] = cur_src_reg;
                prdata[oscsw_pkg::NEXT_LSB +: 3] = next_src_reg;
                prdata[oscsw_pkg::FREEZE_BIT] = freeze_reg;
                prdata[oscsw_pkg::LOCK_BIT] = lock_view;
                prdata[oscsw_pkg::FAIL_BIT] = fail_reg;
                prdata[oscsw_pkg::DRIVE_BIT] = drive_reg;
                prdata[oscsw_pkg::SEC_EN_BIT] = sec_en_reg;
                prdata[oscsw_pkg::SWREQ_BIT] = swreq_reg;
            end
            oscsw_pkg::ADDR_CLK_DIV: begin
                prdata[oscsw_pkg::WAKE_BIT] = wake_reg;
                prdata[oscsw_pkg::RATIO_LSB +: 3] = ratio_reg;
                prdata[oscsw_pkg::SLOW_EN_BIT] = slow_en_reg;
                prdata[oscsw_pkg::POST_LSB +: 3] = post_reg;
            end
            oscsw_pkg::ADDR_FRC_TRIM: begin
                prdata[5:0] = trim_reg;
            end
            oscsw_pkg::ADDR_OSC_STAT: begin
                prdata[2:0] = state_reg;
                prdata[4:3] = ul_hi_reg;
                prdata[6:5] = ul_lo_reg;
            end
            default: begin
                prdata = 32'h0;
            end
        endcase
    end

endmodule
`default_nettype wire
